// ==== rtl/pils_pkg.sv ====
// Constants, types and level decode for the priority interrupt level system
package pils_pkg;
  localparam int NLVL  = 38;
  localparam int LVL_W = 6;
  localparam int ACC_W = 16;
  localparam int CNT_W = 16;
  localparam int LOC_W = 10;

  // APB register offsets
  localparam logic [7:0] OFS_CTRL_WRITE = 8'h00;
  localparam logic [7:0] OFS_STATUS_RD  = 8'h04;
  localparam logic [7:0] OFS_PSW        = 8'h08;
  localparam logic [7:0] OFS_ACK        = 8'h0c;
  localparam logic [7:0] OFS_CNT2_LOC   = 8'h10;
  localparam logic [7:0] OFS_CNT1_LOC   = 8'h14;

  // Field positions
  localparam int CODE_LSB     = 16;
  localparam int GRP_LSB      = 20;
  localparam int PSW_II_BIT   = 0;
  localparam int PSW_EI_BIT   = 1;
  localparam int ACK_REQ_BIT  = 8;
  localparam int ACK_HOLD_BIT = 9;
  localparam int TRACE_BIT    = 4;

  localparam logic [3:0] GRP_STD   = 4'h0;
  localparam logic [3:0] GRP_OPT_A = 4'h5;
  localparam logic [3:0] GRP_OPT_B = 4'h6;

  localparam logic [2:0] RD_ARMED   = 3'h1;
  localparam logic [2:0] RD_WAITING = 3'h2;
  localparam logic [2:0] RD_ENABLED = 3'h4;

  // Level indices in priority order (index 0 is priority 3)
  localparam int LV_CNT2     = 0;
  localparam int LV_CNT1     = 1;
  localparam int LV_FAULT    = 2;
  localparam int LV_PROT     = 3;
  localparam int LV_II_FIRST = 4;
  localparam int LV_IO       = 6;
  localparam int LV_PANEL    = 7;
  localparam int LV_C2Z      = 8;
  localparam int LV_C1Z      = 9;
  localparam int LV_INT1     = 10;
  localparam int LV_II_LAST  = 13;
  localparam int LV_OPT_A    = 14;
  localparam int LV_OPT_B    = 30;

  localparam logic [LOC_W-1:0] LOC_CNT2  = 10'h0fe;
  localparam logic [LOC_W-1:0] LOC_FAULT = 10'h102;
  localparam logic [LOC_W-1:0] LOC_IO    = 10'h106;
  localparam logic [LOC_W-1:0] LOC_INT5  = 10'h108;
  localparam logic [LOC_W-1:0] LOC_C2Z   = 10'h10a;
  localparam logic [LOC_W-1:0] LOC_OPT   = 10'h110;

  typedef enum logic [2:0] {
    CODE_SET_ACTIVE = 3'h0, CODE_DISARM  = 3'h1, CODE_ARM_EN  = 3'h2, CODE_ARM_DIS = 3'h3,
    CODE_ENABLE     = 3'h4, CODE_DISABLE = 3'h5, CODE_EN_ONLY = 3'h6, CODE_TRIGGER = 3'h7
  } pils_code_t;

  // Bit 0 is the armed flop, bit 1 the waiting flop
  typedef enum logic [1:0] {
    ST_DISARMED = 2'b00, ST_ARMED = 2'b01, ST_WAITING = 2'b11, ST_ACTIVE = 2'b10
  } pils_state_t;

  typedef struct packed {
    logic        cnt2_pulse;
    logic        cnt1_pulse;
    logic        fault_nonzero;
    logic        fault_panel_en;
    logic        protect_en;
    logic        protect_viol;
    logic        io_irq;
    logic        panel_switch;
    logic        panel_kbd_seq;
    logic [5:0]  integral;
    logic [23:0] opt_irq;
  } pils_src_t;

  function automatic logic [3:0] lvl_group(input int i);
    if (i >= LV_OPT_B) return GRP_OPT_B;
    if (i >= LV_OPT_A) return GRP_OPT_A;
    return GRP_STD;
  endfunction

  function automatic logic [3:0] lvl_bit(input int i);
    if (i >= LV_OPT_B) return 4'(i - LV_OPT_B);
    if (i >= LV_OPT_A) return 4'(i - LV_OPT_A);
    case (i)
      LV_CNT2:  return 4'h2;
      LV_CNT1:  return 4'h3;
      LV_FAULT: return 4'h0;
      LV_PROT:  return 4'h1;
      LV_IO:    return 4'h6;
      LV_PANEL: return 4'h7;
      default:  return (i < LV_IO) ? 4'(i + 4) : 4'(i + 2);
    endcase
  endfunction

  function automatic logic [LOC_W-1:0] lvl_loc(input int i);
    if (i >= LV_OPT_A) return LOC_OPT + LOC_W'(i - LV_OPT_A);
    if (i >= LV_C2Z)   return LOC_C2Z + LOC_W'(i - LV_C2Z);
    if (i >= LV_IO)    return LOC_IO + LOC_W'(i - LV_IO);
    if (i >= LV_II_FIRST) return LOC_INT5 + LOC_W'(i - LV_II_FIRST);
    if (i >= LV_FAULT) return LOC_FAULT + LOC_W'(i - LV_FAULT);
    return LOC_CNT2 + LOC_W'(i);
  endfunction
endpackage

// ==== rtl/pils_core.sv ====
// Priority interrupt level system with APB register access
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Counter levels ignore the internal inhibit and accept count pulses whenever armed.
// - Counter 2 ranks third, counter 1 fourth in priority order, but neither enters the chain.
// - Machine fault triggers on nonzero fault with panel enable; reads bit 0; uncontrollable.
// - Protection violation, sixth, triggers on violation when enabled; reads bit 1; uncontrollable.
// - I/O level takes I/O interrupts, uses bit 6, masked by internal inhibit.
// - Panel level from switch or keyboard sequence, uses bit 7, internal inhibit masks.
// - Counter-zero level triggers when its counter increments to zero; counting continues.
// - Counter-zero levels at bits 10 and 11, controllable, internal inhibit masks.
// - Six integral levels in group 0 are readable, controllable, internally inhibited.
// - Optional groups give 24 levels, all masked by the external inhibit.
// - Group 5 holds optional levels at bits 0-15, group 6 at bits 0-7.
// - Each level holds armed, waiting and enable flops; four exclusive states.
// - A disarmed level drops incoming signals without record.
// - An armed level captures a signal and moves to waiting.
// - A disabled level never goes waiting to active and leaves the chain.
// - Waiting goes active only if enabled, uninhibited, unblocked and CPU interruptible.
// - Acknowledge presents the level's dedicated location for status pair storage.
// - No further acknowledge until the first service instruction completes.
// - Active level stays active until exit, or a write arms or disarms it.
// - Higher eligible levels preempt an active level; lower ones never do.
// - Status read returns one chosen flop of each level in the addressed group into the accumulator.
// - A pulse on an armed enabled counter level adds one and re-arms it.
// - Read code 010 returns the waiting flops of the addressed group.
// - Trigger code 111 advances selected armed levels to waiting like a device signal.
module pils_core (
  // APB slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Interrupt sources and trace switch
  input  wire pils_pkg::pils_src_t       src,
  input  wire logic                      trace_switch,
  // CPU sequencer
  input  wire logic                      cpu_interruptible,
  input  wire logic                      ack_grant,
  input  wire logic                      first_instr_done,
  input  wire logic                      exit_req,
  output logic                           ack_req,
  output logic [pils_pkg::LVL_W-1:0]     ack_level,
  output logic [pils_pkg::LOC_W-1:0]     ack_loc
);
  localparam int N = pils_pkg::NLVL;

  pils_pkg::pils_state_t        st_reg [N];
  logic [N-1:0]                 en_reg;
  logic [N-1:0]                 armed_flop;
  logic [N-1:0]                 waiting_flop;
  logic [N-1:0]                 active;
  logic [N-1:0]                 inhibited;
  logic [N-1:0]                 elig;
  logic [N-1:0]                 hw_trig;
  logic [31:0]                  wd_reg;
  logic [31:0]                  rdsel_reg;
  logic                         internal_group_inhibit;
  logic                         external_group_inhibit;
  logic [pils_pkg::CNT_W-1:0]   cnt2_reg;
  logic [pils_pkg::CNT_W-1:0]   cnt1_reg;
  logic                         hold_reg;
  logic                         ack_req_reg;
  logic [pils_pkg::LVL_W-1:0]   ack_level_reg;
  logic [pils_pkg::LOC_W-1:0]   ack_loc_reg;
  logic [31:0]                  prdata_reg;

  // APB decode
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire addr_hit  = (paddr == pils_pkg::OFS_CTRL_WRITE) | (paddr == pils_pkg::OFS_STATUS_RD) |
                   (paddr == pils_pkg::OFS_PSW) | (paddr == pils_pkg::OFS_ACK) |
                   (paddr == pils_pkg::OFS_CNT2_LOC) | (paddr == pils_pkg::OFS_CNT1_LOC);
  wire wr_fire   = access_ph & pwrite & addr_hit;
  wire wd_fire   = wr_fire & (paddr == pils_pkg::OFS_CTRL_WRITE);
  wire cnt2_wr   = wr_fire & (paddr == pils_pkg::OFS_CNT2_LOC);
  wire cnt1_wr   = wr_fire & (paddr == pils_pkg::OFS_CNT1_LOC);
  wire [pils_pkg::ACC_W-1:0] wd_acc = pwdata[pils_pkg::ACC_W-1:0];
  wire pils_pkg::pils_code_t wd_code = pils_pkg::pils_code_t'(pwdata[pils_pkg::CODE_LSB +: 3]);
  wire [3:0] wd_grp = pwdata[pils_pkg::GRP_LSB +: 4];
  wire [2:0] rd_code = rdsel_reg[pils_pkg::CODE_LSB +: 3];
  wire [3:0] rd_grp  = rdsel_reg[pils_pkg::GRP_LSB +: 4];

  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_hit;
  assign prdata  = prdata_reg;

  logic psw_ii;
  logic psw_ei;
  assign internal_group_inhibit = psw_ii;
  assign external_group_inhibit = psw_ei;

  // Counters are serviced straight away when waiting and enabled; they never enter the chain
  wire cnt2_svc = (st_reg[pils_pkg::LV_CNT2] == pils_pkg::ST_WAITING) & en_reg[pils_pkg::LV_CNT2];
  wire cnt1_svc = (st_reg[pils_pkg::LV_CNT1] == pils_pkg::ST_WAITING) & en_reg[pils_pkg::LV_CNT1];
  wire cnt2_zero = cnt2_svc & (cnt2_reg == {pils_pkg::CNT_W{1'b1}});
  wire cnt1_zero = cnt1_svc & (cnt1_reg == {pils_pkg::CNT_W{1'b1}});

  // Device and counter-zero trigger inputs in priority order
  assign hw_trig[pils_pkg::LV_CNT2]  = src.cnt2_pulse;
  assign hw_trig[pils_pkg::LV_CNT1]  = src.cnt1_pulse;
  assign hw_trig[pils_pkg::LV_FAULT] = src.fault_nonzero & src.fault_panel_en;
  assign hw_trig[pils_pkg::LV_PROT]  = src.protect_en & src.protect_viol;
  assign hw_trig[pils_pkg::LV_IO-1:pils_pkg::LV_II_FIRST] = src.integral[5:4];
  assign hw_trig[pils_pkg::LV_IO]    = src.io_irq;
  assign hw_trig[pils_pkg::LV_PANEL] = src.panel_switch | src.panel_kbd_seq;
  assign hw_trig[pils_pkg::LV_C2Z]   = cnt2_zero;
  assign hw_trig[pils_pkg::LV_C1Z]   = cnt1_zero;
  assign hw_trig[pils_pkg::LV_OPT_A-1:pils_pkg::LV_INT1] = src.integral[3:0];
  assign hw_trig[N-1:pils_pkg::LV_OPT_A] = src.opt_irq;

  // Chain resolver
  logic                       win_found;
  logic                       win_act;
  logic [pils_pkg::LVL_W-1:0] win_idx;
  logic                       act_found;
  logic [pils_pkg::LVL_W-1:0] act_idx;

  always_comb begin
    win_found = 1'b0;
    win_act   = 1'b0;
    win_idx   = '0;
    act_found = 1'b0;
    act_idx   = '0;
    for (int k = N - 1; k >= pils_pkg::LV_FAULT; k--) begin
      if (active[k] | elig[k]) begin
        win_found = 1'b1;
        win_act   = active[k];
        win_idx   = pils_pkg::LVL_W'(k);
      end
      if (active[k]) begin
        act_found = 1'b1;
        act_idx   = pils_pkg::LVL_W'(k);
      end
    end
  end

  wire grant_fire = ack_grant & ack_req_reg;
  wire exit_fire  = exit_req & act_found;
  wire ack_req_next = win_found & ~win_act & cpu_interruptible & ~hold_reg & ~grant_fire;

  // Per-level state
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_lvl
      localparam logic [3:0] GRP = pils_pkg::lvl_group(gi);
      localparam logic [3:0] BIT = pils_pkg::lvl_bit(gi);
      localparam bit CTL    = (gi != pils_pkg::LV_FAULT) && (gi != pils_pkg::LV_PROT);
      localparam bit SETACT = (gi >= pils_pkg::LV_II_FIRST);
      localparam bit IS_CNT = (gi <= pils_pkg::LV_CNT1);
      wire in_grp = wd_fire & CTL & (wd_grp == GRP);
      wire sel    = in_grp & wd_acc[BIT];
      pils_pkg::pils_state_t st_next;
      logic                  en_next;

      assign armed_flop[gi]   = st_reg[gi][0];
      assign waiting_flop[gi] = st_reg[gi][1];
      assign active[gi]    = (st_reg[gi] == pils_pkg::ST_ACTIVE);
      assign inhibited[gi] = (gi >= pils_pkg::LV_OPT_A) ? external_group_inhibit :
                             (gi >= pils_pkg::LV_II_FIRST) ? internal_group_inhibit : 1'b0;
      assign elig[gi] = ~IS_CNT & (st_reg[gi] == pils_pkg::ST_WAITING) & en_reg[gi] & ~inhibited[gi];

      always_comb begin
        st_next = st_reg[gi];
        en_next = en_reg[gi];
        if (grant_fire && ack_level_reg == pils_pkg::LVL_W'(gi) && st_reg[gi] == pils_pkg::ST_WAITING) begin
          st_next = pils_pkg::ST_ACTIVE;
        end
        if (exit_fire && act_idx == pils_pkg::LVL_W'(gi)) begin
          st_next = pils_pkg::ST_ARMED;
        end
        if (IS_CNT && st_reg[gi] == pils_pkg::ST_WAITING && en_reg[gi]) begin
          st_next = pils_pkg::ST_ARMED;
        end
        if (in_grp && wd_code == pils_pkg::CODE_EN_ONLY) begin
          en_next = wd_acc[BIT];
        end
        if (sel) begin
          case (wd_code)
            pils_pkg::CODE_SET_ACTIVE: begin
              if (SETACT && st_reg[gi] == pils_pkg::ST_ACTIVE) begin
                st_next = pils_pkg::ST_DISARMED;
              end else if (SETACT && st_reg[gi] != pils_pkg::ST_DISARMED) begin
                st_next = pils_pkg::ST_ACTIVE;
              end
            end
            pils_pkg::CODE_DISARM: st_next = pils_pkg::ST_DISARMED;
            pils_pkg::CODE_ARM_EN: begin
              st_next = pils_pkg::ST_ARMED;
              en_next = 1'b1;
            end
            pils_pkg::CODE_ARM_DIS: begin
              st_next = pils_pkg::ST_ARMED;
              en_next = 1'b0;
            end
            pils_pkg::CODE_ENABLE:  en_next = 1'b1;
            pils_pkg::CODE_DISABLE: en_next = 1'b0;
            pils_pkg::CODE_EN_ONLY: en_next = 1'b1;
            pils_pkg::CODE_TRIGGER: begin
              if (st_reg[gi] == pils_pkg::ST_ARMED) begin
                st_next = pils_pkg::ST_WAITING;
              end
            end
            default: st_next = st_reg[gi];
          endcase
        end
        // A device signal arriving with a write still lands; disarmed levels drop it
        if (hw_trig[gi] && st_next == pils_pkg::ST_ARMED) begin
          st_next = pils_pkg::ST_WAITING;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg[gi] <= CTL ? pils_pkg::ST_DISARMED : pils_pkg::ST_ARMED;
          en_reg[gi] <= ~CTL;
        end else begin
          st_reg[gi] <= st_next;
          en_reg[gi] <= en_next;
        end
      end
    end
  endgenerate

  // Status read: gather the chosen flop of each level in the addressed group
  logic [pils_pkg::ACC_W-1:0] rd_acc;
  always_comb begin
    rd_acc = '0;
    for (int k = 0; k < N; k++) begin
      if (rd_grp == pils_pkg::lvl_group(k)) begin
        case (rd_code)
          pils_pkg::RD_ARMED:   rd_acc[pils_pkg::lvl_bit(k)] = armed_flop[k];
          pils_pkg::RD_WAITING: rd_acc[pils_pkg::lvl_bit(k)] = waiting_flop[k];
          pils_pkg::RD_ENABLED: rd_acc[pils_pkg::lvl_bit(k)] = en_reg[k];
          default:              rd_acc[pils_pkg::lvl_bit(k)] = 1'b0;
        endcase
      end
    end
    if (rd_grp == pils_pkg::GRP_STD) begin
      rd_acc[pils_pkg::TRACE_BIT] = trace_switch;
    end
  end

  logic [31:0] rd_word;
  always_comb begin
    case (paddr)
      pils_pkg::OFS_CTRL_WRITE: rd_word = wd_reg;
      pils_pkg::OFS_STATUS_RD:  rd_word = {rdsel_reg[31:pils_pkg::ACC_W], rd_acc};
      pils_pkg::OFS_PSW:        rd_word = {30'h0, psw_ei, psw_ii};
      pils_pkg::OFS_ACK:        rd_word = {22'h0, hold_reg, ack_req_reg, 2'h0, ack_level_reg};
      pils_pkg::OFS_CNT2_LOC:   rd_word = {16'h0, cnt2_reg};
      pils_pkg::OFS_CNT1_LOC:   rd_word = {16'h0, cnt1_reg};
      default:                  rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_reg     <= 32'h0;
      rdsel_reg  <= 32'h0;
      psw_ii     <= 1'b0;
      psw_ei     <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      if (setup_ph) begin
        prdata_reg <= rd_word;
      end
      if (wd_fire) begin
        wd_reg <= pwdata;
      end
      if (wr_fire && paddr == pils_pkg::OFS_STATUS_RD) begin
        rdsel_reg <= {pwdata[31:pils_pkg::ACC_W], 16'h0};
      end
      if (wr_fire && paddr == pils_pkg::OFS_PSW) begin
        psw_ii <= pwdata[pils_pkg::PSW_II_BIT];
        psw_ei <= pwdata[pils_pkg::PSW_EI_BIT];
      end
    end
  end

  // Counter locations; a software write in the same cycle as a count wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt2_reg <= '0;
      cnt1_reg <= '0;
    end else begin
      if (cnt2_wr) begin
        cnt2_reg <= pwdata[pils_pkg::CNT_W-1:0];
      end else if (cnt2_svc) begin
        cnt2_reg <= cnt2_reg + 16'h1;
      end
      if (cnt1_wr) begin
        cnt1_reg <= pwdata[pils_pkg::CNT_W-1:0];
      end else if (cnt1_svc) begin
        cnt1_reg <= cnt1_reg + 16'h1;
      end
    end
  end

  // Acknowledge handshake toward the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg      <= 1'b0;
      ack_req_reg   <= 1'b0;
      ack_level_reg <= '0;
      ack_loc_reg   <= '0;
    end else begin
      if (grant_fire) begin
        hold_reg <= 1'b1;
      end else if (first_instr_done) begin
        hold_reg <= 1'b0;
      end
      ack_req_reg   <= ack_req_next;
      ack_level_reg <= win_idx;
      ack_loc_reg   <= pils_pkg::lvl_loc(int'(win_idx));
    end
  end

  assign ack_req   = ack_req_reg;
  assign ack_level = ack_level_reg;
  assign ack_loc   = ack_loc_reg;

  // Checks
  ack_needs_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_req_reg |-> $past(cpu_interruptible) && $past(elig[win_idx]))
    else $error("acknowledge request without an eligible level");
  grant_holds_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    grant_fire |=> !ack_req_reg && hold_reg)
    else $error("request raised before first service instruction");
  disarmed_drops_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg[pils_pkg::LV_IO] == pils_pkg::ST_DISARMED) && !wd_fire && src.io_irq
    |=> st_reg[pils_pkg::LV_IO] == pils_pkg::ST_DISARMED)
    else $error("disarmed level recorded a signal");
  armed_captures_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg[pils_pkg::LV_PANEL] == pils_pkg::ST_ARMED) && src.panel_switch && !wd_fire
    |=> st_reg[pils_pkg::LV_PANEL] == pils_pkg::ST_WAITING)
    else $error("armed level missed a signal");
  counter_counts_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt2_svc && !cnt2_wr |=> cnt2_reg == $past(cnt2_reg) + 16'h1)
    else $error("counter pulse not counted");
  zero_triggers_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt1_zero && (st_reg[pils_pkg::LV_C1Z] == pils_pkg::ST_ARMED) && !wd_fire && !exit_fire
    |=> st_reg[pils_pkg::LV_C1Z] == pils_pkg::ST_WAITING)
    else $error("counter zero level not triggered");
  internal_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_req_reg && $past(psw_ii) |-> ack_level_reg < 6'(pils_pkg::LV_II_FIRST) ||
    ack_level_reg >= 6'(pils_pkg::LV_OPT_A))
    else $error("internally inhibited level requested");
  external_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
    ack_req_reg && $past(psw_ei) |-> ack_level_reg < 6'(pils_pkg::LV_OPT_A))
    else $error("externally inhibited level requested");
  fault_uncontrolled_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_fire && !grant_fire && !exit_fire |=> st_reg[pils_pkg::LV_FAULT] == $past(st_reg[pils_pkg::LV_FAULT]) ||
    $past(hw_trig[pils_pkg::LV_FAULT]))
    else $error("fault level changed by control write");
  counter_never_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg[pils_pkg::LV_CNT2] != pils_pkg::ST_ACTIVE && st_reg[pils_pkg::LV_CNT1] != pils_pkg::ST_ACTIVE)
    else $error("counter level went active");
endmodule

`default_nettype wire

// ==== testbench/pils_cpu_model.sv ====
// CPU sequencer model: grants a request after a lag, ends the first instruction, then exits
`timescale 1ns/1ps
`default_nettype none
module pils_cpu_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request side
  input  wire logic       ack_req,
  input  wire logic [1:0] lag,
  // Sequencer pulses
  output logic            ack_grant,
  output logic            first_instr_done,
  output logic            exit_req
);
  logic [3:0] step_reg;
  logic [1:0] wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_reg <= 4'h0;
      wait_reg <= 2'h0;
      ack_grant <= 1'b0;
      first_instr_done <= 1'b0;
      exit_req <= 1'b0;
    end else begin
      ack_grant <= 1'b0;
      first_instr_done <= 1'b0;
      exit_req <= 1'b0;
      if (step_reg != 4'h0) begin
        step_reg <= (step_reg == 4'h6) ? 4'h0 : step_reg + 4'h1;
        first_instr_done <= (step_reg == 4'h3);
        exit_req <= (step_reg == 4'h6);
      end else if (ack_req) begin
        // A slow sequencer leaves the request standing for a few cycles
        wait_reg <= (wait_reg == lag) ? 2'h0 : wait_reg + 2'h1;
        ack_grant <= (wait_reg == lag);
        step_reg <= (wait_reg == lag) ? 4'h1 : 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/priority_interrupt_level_system_tb.sv ====
// Self-checking bench for the priority interrupt level system
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_level_system_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trace_switch = 0, cpu_int = 1;
  logic pready, pslverr, err, ack_grant, first_instr_done, exit_req, ack_req;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] lag = 2'h0;
  pils_pkg::pils_src_t src = '0;
  logic [pils_pkg::LVL_W-1:0] ack_level;
  logic [pils_pkg::LOC_W-1:0] ack_loc;
  int fails = 0, check_count = 0, seed = 32'h59f6, b;
  int exp_q[$];
  always #5 pclk = ~pclk;
  pils_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
    .trace_switch(trace_switch), .cpu_interruptible(cpu_int), .ack_grant(ack_grant),
    .first_instr_done(first_instr_done), .exit_req(exit_req), .ack_req(ack_req),
    .ack_level(ack_level), .ack_loc(ack_loc));
  pils_cpu_model cpu (.pclk(pclk), .presetn(presetn), .ack_req(ack_req), .lag(lag),
    .ack_grant(ack_grant), .first_instr_done(first_instr_done), .exit_req(exit_req));
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(int n);
    if (n >= 60) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    rd = prdata;
    err = pslverr;
    tmo(n);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic cw(input logic [3:0] g, input logic [2:0] c, input logic [15:0] a);
    apb(1, pils_pkg::OFS_CTRL_WRITE, {8'h00, g, 1'b0, c, a});
  endtask
  task automatic rdw(input logic [3:0] g, input logic [15:0] e);
    apb(1, pils_pkg::OFS_STATUS_RD, {8'h00, g, 1'b0, pils_pkg::RD_WAITING, 16'h0000});
    apb(0, pils_pkg::OFS_STATUS_RD, 32'h0);
    chk("waiting", rd[15:0], e);
  endtask
  function automatic int loc_of(int lv);
    if (lv >= 14) return 'h110 + lv - 14;
    if (lv >= 10) return 'h10c + lv - 10;
    if (lv >= 8) return 'h10a + lv - 8;
    if (lv >= 6) return 'h106 + lv - 6;
    if (lv >= 4) return 'h108 + lv - 4;
    if (lv >= 2) return 'h102 + lv - 2;
    return 'hfe + lv;
  endfunction
  task automatic grant(int lv);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (ack_req !== 1'b1 && n < 60);
    tmo(n);
    chk("ack_level", ack_level, lv);
    chk("ack_loc", ack_loc, loc_of(lv));
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (exit_req !== 1'b1 && n < 60);
    tmo(n);
    repeat (2) @(posedge pclk);
  endtask
  task automatic idle();
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    chk("ack_req", ack_req, 0);
    @(posedge pclk);
  endtask
  initial begin
    b = {$random(seed)} % 16;
    lag = 2'($random(seed));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, pils_pkg::OFS_PSW, 32'h0);
    chk("psw", rd, 0);
    apb(0, pils_pkg::OFS_ACK, 32'h0);
    chk("ack", rd, 0);
    apb(0, 8'h40, 32'h0);
    chk("slverr", err, 1);
    apb(1, pils_pkg::OFS_PSW, 32'h1);
    // Counters are only armed, never set active
    cw(pils_pkg::GRP_STD, pils_pkg::CODE_ARM_EN, 16'h0ccc);
    src.io_irq <= 1;
    @(posedge pclk);
    src.io_irq <= 0;
    rdw(pils_pkg::GRP_STD, 16'h0040);
    idle();
    apb(1, pils_pkg::OFS_CNT2_LOC, 32'h0000ffff);
    apb(1, pils_pkg::OFS_CNT1_LOC, 32'h0000ffff);
    src.cnt2_pulse <= 1;
    src.cnt1_pulse <= 1;
    @(posedge pclk);
    src.cnt2_pulse <= 0;
    src.cnt1_pulse <= 0;
    trace_switch <= 1;
    repeat (4) @(posedge pclk);
    apb(0, pils_pkg::OFS_CNT2_LOC, 32'h0);
    chk("cnt2", rd[15:0], 0);
    apb(0, pils_pkg::OFS_CNT1_LOC, 32'h0);
    chk("cnt1", rd[15:0], 0);
    // Trace switch shows at bit 4 of the standard group
    rdw(pils_pkg::GRP_STD, 16'h0c50);
    src.fault_nonzero <= 1;
    src.fault_panel_en <= 1;
    @(posedge pclk);
    src.fault_nonzero <= 0;
    grant(pils_pkg::LV_FAULT);
    cw(pils_pkg::GRP_STD, pils_pkg::CODE_TRIGGER, 16'h0080);
    apb(1, pils_pkg::OFS_PSW, 32'h0);
    exp_q = '{6, 7, 8, 9};
    while (exp_q.size() > 0) grant(exp_q.pop_front());
    cw(pils_pkg::GRP_STD, pils_pkg::CODE_DISABLE, 16'h0040);
    cw(pils_pkg::GRP_STD, pils_pkg::CODE_TRIGGER, 16'h00c0);
    grant(7);
    cw(pils_pkg::GRP_STD, pils_pkg::CODE_ENABLE, 16'h0040);
    grant(6);
    cw(pils_pkg::GRP_OPT_A, pils_pkg::CODE_ARM_EN, 16'(1 << b));
    apb(1, pils_pkg::OFS_PSW, 32'h2);
    src.opt_irq[b] <= 1;
    @(posedge pclk);
    src.opt_irq[b] <= 0;
    idle();
    rdw(pils_pkg::GRP_OPT_A, 16'(1 << b));
    apb(1, pils_pkg::OFS_PSW, 32'h0);
    grant(14 + b);
    cw(pils_pkg::GRP_OPT_B, pils_pkg::CODE_ARM_EN, 16'h0080);
    cpu_int <= 0;
    cw(pils_pkg::GRP_OPT_B, pils_pkg::CODE_TRIGGER, 16'h0080);
    idle();
    cpu_int <= 1;
    grant(37);
    cw(pils_pkg::GRP_OPT_A, pils_pkg::CODE_DISARM, 16'(1 << b));
    src.opt_irq[b] <= 1;
    @(posedge pclk);
    src.opt_irq[b] <= 0;
    rdw(pils_pkg::GRP_OPT_A, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
